// *** design/level_filter.v ***
// per-pin active-level filter: active only after consecutive samples agree
`timescale 1ns/1ps
module level_filter #(
	parameter N = 10
) (
	input wire aclk,
	input wire aresetn,
	input wire strobe,
	input wire [N-1:0] pin_level,
	input wire [N-1:0] polarity,
	output wire [N-1:0] active
);
	reg [N-1:0] s1_reg;
	reg [N-1:0] s2_reg;
	wire [N-1:0] act_now;
	assign act_now = ~(pin_level ^ polarity);
	always @(posedge aclk) begin
		if (!aresetn) begin
			s1_reg <= {N{1'b0}};
			s2_reg <= {N{1'b0}};
		end else if (strobe) begin
			s1_reg <= act_now;
			s2_reg <= s1_reg;
		end
	end
	// two consecutive active samples needed
	assign active = s1_reg & s2_reg;
endmodule // level_filter

// *** design/pin_ctrl.v ***
// general purpose pin controller with axi4-lite register slave
// Notes on behaviour
// - ten bidirectional pins, each configured by its own register bit
// - a pin is general purpose only while its function enable bit is set
// - enabled input pins get pull-up; data register reads live pin level
// - buffer type bit picks push-pull or open-drain for outputs
// - open-drain drives low for data 0, releases pin for data 1
// - push-pull drives the pin to the data bit level
// - outputs disable pull-up, input buffer stays on; reads give pin level
// - pull-up on only while pin is a general purpose input; pins with function enable clear follow normal_pullup
// - each pin has its own event status bit showing its condition
// - enabled status bits are ORed into one request to main interrupt logic
// - events set status regardless of enable bits
// - active level counts only after two consecutive samples
// - polarity 1 means high level active, 0 means low level active
// - per-pin source select low/high bits choose output source
// - buffer type applies to every selectable output source
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "pin_ctrl_map.vh"
module pin_ctrl #(
	parameter N = `NUM_PINS
) (
	input wire aclk,
	input wire aresetn,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [N-1:0] pin_in,
	output reg [N-1:0] pin_out,
	output reg [N-1:0] pin_oe,
	output reg [N-1:0] pin_pullup,
	output reg [N-1:0] pin_gp_sel,
	input wire [N-1:0] normal_out,
	input wire [N-1:0] normal_oe,
	input wire [N-1:0] normal_pullup,
	input wire [N-1:0] alt_src1,
	input wire [N-1:0] alt_src2,
	input wire [N-1:0] alt_src3,
	output reg pin_event_req,
	output reg irq
);
	// ****************************************
	// registers
	// ****************************************
	reg [N-1:0] func_en_reg;
	reg [N-1:0] dir_reg;
	reg [N-1:0] buf_type_reg;
	reg [N-1:0] data_reg;
	reg [N-1:0] evt_status_reg;
	reg [N-1:0] evt_enable_reg;
	reg [N-1:0] evt_polarity_reg;
	reg [N-1:0] sel_low_reg;
	reg [N-1:0] sel_high_reg;
	reg irq_status_reg;
	reg irq_mask_reg;
	reg [7:0] awaddr_reg;
	reg aw_have_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	reg w_have_reg;
	wire strobe;
	wire [N-1:0] active;
	wire do_write;
	wire [N-1:0] wmask;
	wire [N-1:0] clr_status;
	wire [N-1:0] status_next;
	wire req_next;
	reg [N-1:0] out_next;
	reg [N-1:0] oe_next;
	reg [N-1:0] pull_next;
	reg [N-1:0] src;
	integer i;
	// ****************************************
	// sampling and level filter
	// ****************************************
	sample_strobe #(.DIV(`SAMPLE_DIV)) u_strobe (
		.aclk(aclk),
		.aresetn(aresetn),
		.strobe(strobe)
	);
	level_filter #(.N(N)) u_filter (
		.aclk(aclk),
		.aresetn(aresetn),
		.strobe(strobe),
		.pin_level(pin_in),
		.polarity(evt_polarity_reg),
		.active(active)
	);
	// ****************************************
	// write channel
	// ****************************************
	// address and data may come in either order; both latched, then one write
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	// low byte lanes only carry pin bits
	assign wmask = {{(N > 8 ? N - 8 : 0){wstrb_reg[1]}}, {8{wstrb_reg[0]}}} ;
	assign clr_status = (do_write && awaddr_reg == `OFS_EVT_STATUS) ?
		(wdata_reg[N-1:0] & wmask) : {N{1'b0}};
	// level still present sets again; set wins over clear
	assign status_next = (evt_status_reg & ~clr_status) | active;
	assign req_next = |(status_next & evt_enable_reg);
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			func_en_reg <= `RST_PINS;
			dir_reg <= `RST_PINS;
			buf_type_reg <= `RST_PINS;
			data_reg <= `RST_PINS;
			evt_enable_reg <= `RST_PINS;
			evt_polarity_reg <= `RST_PINS;
			sel_low_reg <= `RST_PINS;
			sel_high_reg <= `RST_PINS;
			irq_mask_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg <= s_axi_awaddr;
				aw_have_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				w_have_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'b00;
				case (awaddr_reg)
				`OFS_FUNC_EN: func_en_reg <= (func_en_reg & ~wmask) | (wdata_reg[N-1:0] & wmask);
				`OFS_DIR: dir_reg <= (dir_reg & ~wmask) | (wdata_reg[N-1:0] & wmask);
				`OFS_BUF_TYPE: buf_type_reg <= (buf_type_reg & ~wmask) | (wdata_reg[N-1:0] & wmask);
				`OFS_DATA: data_reg <= (data_reg & ~wmask) | (wdata_reg[N-1:0] & wmask);
				`OFS_EVT_STATUS: ;
				`OFS_EVT_ENABLE: evt_enable_reg <= (evt_enable_reg & ~wmask) |
					(wdata_reg[N-1:0] & wmask);
				`OFS_EVT_POLARITY: evt_polarity_reg <= (evt_polarity_reg & ~wmask) |
					(wdata_reg[N-1:0] & wmask);
				`OFS_SEL_LOW: sel_low_reg <= (sel_low_reg & ~wmask) | (wdata_reg[N-1:0] & wmask);
				`OFS_SEL_HIGH: sel_high_reg <= (sel_high_reg & ~wmask) | (wdata_reg[N-1:0] & wmask);
				`OFS_IRQ_STATUS: ;
				`OFS_IRQ_MASK: begin
					if (wstrb_reg[0]) begin
						irq_mask_reg <= wdata_reg[`IRQ_BIT_PIN_EVT];
					end
				end
				default: s_axi_bresp <= 2'b10;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end
	// ****************************************
	// event status and interrupt
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			evt_status_reg <= `RST_PINS;
			pin_event_req <= 1'b0;
			irq_status_reg <= 1'b0;
			irq <= 1'b0;
		end else begin
			evt_status_reg <= status_next;
			pin_event_req <= req_next;
			// sticky; a new request in the clearing cycle keeps the bit
			irq_status_reg <= req_next | (irq_status_reg &
				~(do_write && awaddr_reg == `OFS_IRQ_STATUS && wstrb_reg[0] &&
				wdata_reg[`IRQ_BIT_PIN_EVT]));
			irq <= (req_next | irq_status_reg) & irq_mask_reg;
		end
	end
	// ****************************************
	// read channel
	// ****************************************
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h00000000;
			case (s_axi_araddr)
			`OFS_FUNC_EN: s_axi_rdata[N-1:0] <= func_en_reg;
			`OFS_DIR: s_axi_rdata[N-1:0] <= dir_reg;
			`OFS_BUF_TYPE: s_axi_rdata[N-1:0] <= buf_type_reg;
			// live pin level, never the written value
			`OFS_DATA: s_axi_rdata[N-1:0] <= pin_in;
			`OFS_EVT_STATUS: s_axi_rdata[N-1:0] <= evt_status_reg;
			`OFS_EVT_ENABLE: s_axi_rdata[N-1:0] <= evt_enable_reg;
			`OFS_EVT_POLARITY: s_axi_rdata[N-1:0] <= evt_polarity_reg;
			`OFS_SEL_LOW: s_axi_rdata[N-1:0] <= sel_low_reg;
			`OFS_SEL_HIGH: s_axi_rdata[N-1:0] <= sel_high_reg;
			`OFS_IRQ_STATUS: s_axi_rdata[`IRQ_BIT_PIN_EVT] <= irq_status_reg;
			`OFS_IRQ_MASK: s_axi_rdata[`IRQ_BIT_PIN_EVT] <= irq_mask_reg;
			default: s_axi_rresp <= 2'b10;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	// ****************************************
	// pin drivers
	// ****************************************
	always @* begin
		out_next = {N{1'b0}};
		oe_next = {N{1'b0}};
		pull_next = {N{1'b0}};
		src = {N{1'b0}};
		for (i = 0; i < N; i = i + 1) begin
			case ({sel_high_reg[i], sel_low_reg[i]})
			2'b00: src[i] = data_reg[i];
			2'b01: src[i] = alt_src1[i];
			2'b10: src[i] = alt_src2[i];
			default: src[i] = alt_src3[i];
			endcase
			if (!func_en_reg[i]) begin
				out_next[i] = normal_out[i];
				oe_next[i] = normal_oe[i];
				pull_next[i] = normal_pullup[i];
			end else if (!dir_reg[i]) begin
				// input: pull-up on, driver off
				pull_next[i] = 1'b1;
			end else if (buf_type_reg[i]) begin
				// open drain: low for 0, released for 1
				out_next[i] = 1'b0;
				oe_next[i] = ~src[i];
			end else begin
				// push-pull, pull-up off
				out_next[i] = src[i];
				oe_next[i] = 1'b1;
			end
		end
	end
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_out <= `RST_PINS;
			pin_oe <= `RST_PINS;
			pin_pullup <= `RST_PINS;
			pin_gp_sel <= `RST_PINS;
		end else begin
			pin_out <= out_next;
			pin_oe <= oe_next;
			pin_pullup <= pull_next;
			pin_gp_sel <= func_en_reg;
		end
	end
endmodule // pin_ctrl

// *** design/pin_ctrl_map.vh ***
// register offsets, field widths and timing counts of the pin controller
`ifndef PIN_CTRL_MAP_VH
`define PIN_CTRL_MAP_VH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_FUNC_EN      8'h00
`define OFS_DIR          8'h04
`define OFS_BUF_TYPE     8'h08
`define OFS_DATA         8'h0c
`define OFS_EVT_STATUS   8'h10
`define OFS_EVT_ENABLE   8'h14
`define OFS_EVT_POLARITY 8'h18
`define OFS_SEL_LOW      8'h1c
`define OFS_SEL_HIGH     8'h20
`define OFS_IRQ_STATUS   8'h24
`define OFS_IRQ_MASK     8'h28
// ****************************************
// reset values and fields
// ****************************************
`define NUM_PINS         10
`define RST_PINS         10'h000
`define IRQ_BIT_PIN_EVT  0
// ****************************************
// timing: 25 mhz sample rate from 10 mhz clock, so the strobe is high on every clock
// ****************************************
`define CLK_HZ           10000000
`define SAMPLE_HZ        25000000
`define SAMPLE_DIV       ((`CLK_HZ / `SAMPLE_HZ) < 1 ? 1 : (`CLK_HZ / `SAMPLE_HZ))
`define FILTER_SAMPLES   2
`endif

// *** design/sample_strobe.v ***
// divider that makes the one-cycle level sampling strobe
`timescale 1ns/1ps
module sample_strobe #(
	parameter DIV = 1
) (
	input wire aclk,
	input wire aresetn,
	output reg strobe
);
	reg [15:0] cnt_reg;
	// the 25 mhz rate exceeds the 10 mhz clock, so every clock is a sample point
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= 16'h0000;
			strobe <= 1'b0;
		end else if (cnt_reg >= DIV[15:0] - 16'h0001) begin
			cnt_reg <= 16'h0000;
			strobe <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 16'h0001;
			strobe <= 1'b0;
		end
	end
endmodule // sample_strobe

// *** test/board_pins.sv ***
// board side of the shared pins: external drivers, pull-ups, floating lines
`timescale 1ns/1ps
module board_pins (
	input wire aclk,
	input wire [9:0] pin_out,
	input wire [9:0] pin_oe,
	input wire [9:0] pin_pullup,
	input wire [9:0] ext_drive,
	input wire [9:0] ext_en,
	output wire [9:0] pin_level
);
	reg [9:0] float_reg = 10'h155;
	// a line with nobody driving and no pull-up must not look stable
	always @(posedge aclk) begin
		float_reg <= ~float_reg;
	end
	assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drive)
		| (~pin_oe & ~ext_en & (pin_pullup | float_reg));
endmodule // board_pins

// *** test/pin_ctrl_assertions.sv ***
// port checker of the pin controller
`timescale 1ns/1ps
module pin_ctrl_checker #(
	parameter N = 10
) (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_bready,
	input wire [N-1:0] pin_out,
	input wire [N-1:0] pin_oe,
	input wire [N-1:0] pin_pullup,
	input wire [N-1:0] pin_gp_sel,
	input wire [N-1:0] normal_out,
	input wire [N-1:0] normal_oe,
	input wire pin_event_req,
	input wire irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ****************************************
	// assertions
	// ****************************************
	pull_drive_a: assert property ((pin_pullup & pin_oe & pin_gp_sel) == 0)
		else $error("pull-up on while a pin drives");
	normal_path_a: assert property ($past(aresetn) |->
		(((pin_out ^ $past(normal_out)) | (pin_oe ^ $past(normal_oe))) & ~pin_gp_sel) == 0)
		else $error("normal function not passed through");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while busy");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while busy");
	rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:N] == 0)
		else $error("read data above the pins not zero");
	unmapped_resp_a: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr > 8'h28 |=> s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	cover property ($rose(pin_event_req));
	cover property ($rose(irq));
	cover property (s_axi_bvalid && s_axi_bready);
endmodule // pin_ctrl_checker
bind pin_ctrl pin_ctrl_checker #(.N(N)) u_checker (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
	.s_axi_bready, .pin_out, .pin_oe, .pin_pullup, .pin_gp_sel, .normal_out,
	.normal_oe, .pin_event_req, .irq);

// *** test/testbench.sv ***
// self-checking bench of the pin controller
`timescale 1ns/1ps
`include "pin_ctrl_map.vh"
module testbench;
	reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg [7:0] s_axi_awaddr, s_axi_araddr;
	reg [31:0] s_axi_wdata;
	reg [9:0] normal_out, normal_oe, normal_pullup, alt_src1, alt_src2, alt_src3;
	reg [9:0] ext_drive, ext_en;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire pin_event_req, irq;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [9:0] pin_in, pin_out, pin_oe, pin_pullup, pin_gp_sel;
	integer fail_count, checks, k;
	pin_ctrl u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
		.pin_oe, .pin_pullup, .pin_gp_sel, .normal_out, .normal_oe, .normal_pullup,
		.alt_src1, .alt_src2, .alt_src3, .pin_event_req, .irq);
	board_pins u_board (.aclk, .pin_out, .pin_oe, .pin_pullup, .ext_drive, .ext_en,
		.pin_level(pin_in));
	always #50 aclk = ~aclk;
	// ****************************************
	// bus and compare tasks
	// ****************************************
	task cmp(input string nm, input [31:0] e, input [31:0] g);
		begin
			checks = checks + 1;
			if (g !== e) begin
				fail_count = fail_count + 1;
				$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge aclk);
	endtask
	task wr(input [7:0] a, input [31:0] v);
		begin
			@(posedge aclk);
			s_axi_awaddr <= a;
			s_axi_wdata <= v;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (!s_axi_bvalid);
			s_axi_bready <= 1'b0;
			cmp("bresp", (a > `OFS_IRQ_MASK) ? 2'h2 : 2'h0, s_axi_bresp);
		end
	endtask
	task rdc(input [7:0] a, input [31:0] e, input [1:0] resp);
		begin
			@(posedge aclk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (!s_axi_rvalid);
			s_axi_rready <= 1'b0;
			cmp("rdata", e, s_axi_rdata);
			cmp("rresp", resp, s_axi_rresp);
		end
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	task t_normal;
		begin
			normal_out <= 10'h2aa;
			normal_oe <= 10'h0f0;
			normal_pullup <= 10'h00f;
			tick(3);
			cmp("pin_out", 10'h2aa, pin_out);
			cmp("pin_oe", 10'h0f0, pin_oe);
			cmp("pin_pullup", 10'h00f, pin_pullup);
			cmp("pin_gp_sel", 10'h000, pin_gp_sel);
			rdc(`OFS_DIR, 32'h0, 2'h0);
			rdc(8'h2c, 32'h0, 2'h2);
			wr(8'h2c, 32'h3ff);
			rdc(`OFS_FUNC_EN, 32'h0, 2'h0);
			$display("normal function test done");
		end
	endtask
	task t_output;
		begin
			wr(`OFS_FUNC_EN, 32'h3ff);
			wr(`OFS_DIR, 32'h3ff);
			wr(`OFS_DATA, 32'h155);
			tick(3);
			cmp("pin_out", 10'h155, pin_out);
			cmp("pin_oe", 10'h3ff, pin_oe);
			cmp("pin_pullup", 10'h000, pin_pullup);
			rdc(`OFS_DATA, 32'h155, 2'h0);
			wr(`OFS_BUF_TYPE, 32'h3ff);
			ext_en <= 10'h3ff;
			ext_drive <= 10'h000;
			tick(3);
			cmp("pin_out", 10'h000, pin_out);
			cmp("pin_oe", 10'h2aa, pin_oe);
			rdc(`OFS_DATA, 32'h0, 2'h0);
			$display("output test done");
		end
	endtask
	task t_input;
		begin
			ext_en <= 10'h000;
			wr(`OFS_DIR, 32'h0);
			tick(3);
			cmp("pin_pullup", 10'h3ff, pin_pullup);
			cmp("pin_oe", 10'h000, pin_oe);
			rdc(`OFS_DATA, 32'h3ff, 2'h0);
			ext_en <= 10'h3ff;
			ext_drive <= 10'h2a5;
			tick(3);
			rdc(`OFS_DATA, 32'h2a5, 2'h0);
			$display("input test done");
		end
	endtask
	task t_event;
		begin
			ext_drive <= 10'h000;
			wr(`OFS_EVT_POLARITY, 32'h3ff);
			wr(`OFS_EVT_STATUS, 32'h3ff);
			tick(3);
			ext_drive <= 10'h001;
			@(posedge aclk) ext_drive <= 10'h000;
			tick(5);
			rdc(`OFS_EVT_STATUS, 32'h0, 2'h0);
			ext_drive <= 10'h001;
			tick(5);
			rdc(`OFS_EVT_STATUS, 32'h1, 2'h0);
			cmp("pin_event_req", 1'b0, pin_event_req);
			wr(`OFS_EVT_ENABLE, 32'h1);
			wr(`OFS_IRQ_MASK, 32'h1);
			tick(4);
			cmp("pin_event_req", 1'b1, pin_event_req);
			cmp("irq", 1'b1, irq);
			rdc(`OFS_IRQ_STATUS, 32'h1, 2'h0);
			wr(`OFS_EVT_STATUS, 32'h1);
			tick(4);
			rdc(`OFS_EVT_STATUS, 32'h1, 2'h0);
			ext_drive <= 10'h000;
			wr(`OFS_EVT_STATUS, 32'h1);
			wr(`OFS_IRQ_STATUS, 32'h1);
			tick(4);
			rdc(`OFS_EVT_STATUS, 32'h0, 2'h0);
			cmp("irq", 1'b0, irq);
			wr(`OFS_EVT_POLARITY, 32'h3fd);
			tick(5);
			rdc(`OFS_EVT_STATUS, 32'h2, 2'h0);
			$display("event test done");
		end
	endtask
	task t_select;
		begin
			alt_src1 <= 10'h0f0;
			alt_src2 <= 10'h30f;
			alt_src3 <= 10'h155;
			wr(`OFS_DIR, 32'h3ff);
			wr(`OFS_BUF_TYPE, 32'h0);
			for (k = 1; k < 4; k = k + 1) begin
				wr(`OFS_SEL_LOW, {10{k[0]}});
				wr(`OFS_SEL_HIGH, {10{k[1]}});
				tick(3);
				cmp("pin_out", k == 1 ? alt_src1 : k == 2 ? alt_src2 : alt_src3, pin_out);
			end
			wr(`OFS_BUF_TYPE, 32'h3ff);
			tick(3);
			cmp("pin_oe", 10'h2aa, pin_oe);
			$display("source select test done");
		end
	endtask
	task test_done;
		begin
			$display("checks %0d fail_count %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	// ****************************************
	// main sequence and watchdog
	// ****************************************
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
		{normal_out, normal_oe, normal_pullup, alt_src1, alt_src2, alt_src3} = 60'h0;
		{ext_drive, ext_en, fail_count, checks} = 84'h0;
		tick(2);
		aresetn <= 1'b1;
		t_normal;
		t_output;
		t_input;
		t_event;
		t_select;
		test_done;
	end
	initial begin
		#2000000;
		fail_count = fail_count + 1;
		test_done;
	end
endmodule // testbench
